// ==== cgb_pkg.sv ====
package cgb_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OUTPUT_PAIR_ENABLE = 8'h00;
  localparam logic [7:0] IDX_SPREAD_AND_SWING = 8'h01;
  localparam logic [7:0] IDX_PAIR_EDGE_RATE = 8'h02;
  localparam logic [7:0] IDX_SINGLE_ENDED_CTRL = 8'h03;
  localparam logic [7:0] IDX_RESERVED_ALL_ONES = 8'h04;
  localparam logic [7:0] IDX_REVISION_AND_VENDOR = 8'h05;
  localparam logic [7:0] IDX_FAMILY_AND_PART = 8'h06;
  localparam logic [7:0] IDX_BLOCK_READ_LENGTH = 8'h07;

  // ----------------------------------------------------------------
  // writable masks, fixed read values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAIR_ENABLE_MASK = 8'h06;
  localparam logic [7:0] PAIR_ENABLE_FIXED = 8'hF9;
  localparam logic [7:0] PAIR_ENABLE_RESET = 8'h06;
  localparam logic [7:0] SPREAD_MASK = 8'h3B;
  localparam logic [7:0] SPREAD_FIXED = 8'h04;
  localparam logic [7:0] SPREAD_RESET = 8'h02;
  localparam logic [7:0] EDGE_MASK = 8'h06;
  localparam logic [7:0] EDGE_FIXED = 8'hF9;
  localparam logic [7:0] EDGE_RESET = 8'h06;
  localparam logic [7:0] SE_MASK = 8'hF0;
  localparam logic [7:0] SE_FIXED = 8'h0F;
  localparam logic [7:0] SE_RESET = 8'h50;
  localparam logic [7:0] RESERVED_VALUE = 8'hFF;
  localparam logic [7:0] LENGTH_MASK = 8'h1F;
  localparam logic [7:0] LENGTH_FIXED = 8'h00;
  localparam logic [7:0] LENGTH_RESET = 8'h08;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PAIR1_BIT = 2;
  localparam int PAIR0_BIT = 1;
  localparam int STRAP_LSB = 6;
  localparam int SW_OVERRIDE_BIT = 5;
  localparam int SW_SPREAD_LSB = 3;
  localparam int SWING_LSB = 0;
  localparam int SE_EDGE_LSB = 6;
  localparam int SE_WAKE_BIT = 5;
  localparam int SE_ENABLE_BIT = 4;

  // ----------------------------------------------------------------
  // strap codes, byte roles, bus phases
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  localparam logic [1:0] ROLE_ADDR = 2'h0;
  localparam logic [1:0] ROLE_INDEX = 2'h1;
  localparam logic [1:0] ROLE_COUNT = 2'h2;
  localparam logic [1:0] ROLE_DATA = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  typedef enum logic [2:0] {
    CGB_IDLE,
    CGB_RX,
    CGB_ACK_OUT,
    CGB_TX,
    CGB_ACK_IN
  } cgb_phase_type;

endpackage : cgb_pkg

// ==== cgb_config_bank.sv ====
// Operation
// - byte0 bits 2,1 gate pairs, reset on
// - byte1 bits 7:6 read latched spread strap
// - byte1 bit5 hands spread to software
// - software spread field codes, reset 00
// - software field inert unless override set
// - byte1 bits 1:0 swing, reset 10
// - byte2 bits 2,1 pair edge rate, reset fast
// - byte3 single-ended edge rate and enable
// - byte3 bit5 keeps single-ended running powered down
// - byte4 reads all ones, writes ignored
// - byte5 fixed revision and vendor codes
// - byte6 fixed family and part codes
// - byte7 read length, default 8
// - block write: index, count, data, acked
// - block read returns count then data
`timescale 1ns/100ps
module cgb_config_bank
  import cgb_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR_0 = 7'h2A,  // arbitrary default
  parameter logic [6:0] BUS_ADDR_1 = 7'h2B,  // arbitrary default
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] VENDOR_CODE = 4'h5,  // arbitrary value
  parameter logic [1:0] FAMILY_CODE = 2'h2,  // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h15  // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // system management bus pins
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // straps and power control
  input wire logic ADDR_SELECT,
  input wire logic [1:0] SPREAD_STRAP_CODE,
  input wire logic POWER_GOOD_POWERDOWN_PIN_N,
  // controls to the clock outputs
  output logic PAIR0_OUTPUT_GATE,
  output logic PAIR1_OUTPUT_GATE,
  output logic PAIR0_EDGE_RATE,
  output logic PAIR1_EDGE_RATE,
  output logic [1:0] SPREAD_AMOUNT,
  output logic [1:0] SWING_SELECT,
  output logic [1:0] SE_EDGE_RATE,
  output logic SE_OUTPUT_RUN
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cgb_phase_type phase;  // bus engine phase
    logic [1:0] role;  // meaning of the byte in flight
    logic [3:0] bit_cnt;  // bits moved in this byte
    logic [7:0] shift;  // receive or transmit shifter
    logic [7:0] index;  // register pointer
    logic rw;  // direction bit of the address byte
    logic host_nack;  // host answer after a sent byte
    logic sda_low;  // we pull data low
    logic scl_q;  // previous clock line
    logic sda_q;  // previous data line
    logic strap_taken;  // straps caught once after reset
    logic [1:0] strap;  // latched spread strap
    logic addr_sel;  // latched address select
    logic [7:0] pair_enable;  // stored byte 0
    logic [7:0] spread;  // stored byte 1
    logic [7:0] edge_rate;  // stored byte 2
    logic [7:0] se_ctrl;  // stored byte 3
    logic [7:0] read_length;  // stored byte 7
    logic wr_strobe;  // a data byte was committed
    logic first_tx;  // count byte just loaded
  } cgb_state_type;

  cgb_state_type s;  // registered state
  cgb_state_type next_s;  // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // keep the fixed bits, take only the writable ones
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    merge = (old & ~mask) | (wdata & mask);
  endfunction : merge

  // what a read shows: writable bits stored, the rest fixed
  function automatic logic [7:0] shown(
    input logic [7:0] stored,
    input logic [7:0] mask,
    input logic [7:0] fixed
  );
    shown = (stored & mask) | (fixed & ~mask);
  endfunction : shown

  // read mux over the eight bytes
  function automatic logic [7:0] read_byte(
    input cgb_state_type st,
    input logic [7:0] idx
  );
    case (idx)
      IDX_OUTPUT_PAIR_ENABLE: begin
        read_byte = shown(st.pair_enable, PAIR_ENABLE_MASK,
                          PAIR_ENABLE_FIXED);
      end
      IDX_SPREAD_AND_SWING: begin
        read_byte = shown(st.spread, SPREAD_MASK, SPREAD_FIXED)
                    | {st.strap, 6'h00};
      end
      IDX_PAIR_EDGE_RATE: begin
        read_byte = shown(st.edge_rate, EDGE_MASK, EDGE_FIXED);
      end
      IDX_SINGLE_ENDED_CTRL: begin
        read_byte = shown(st.se_ctrl, SE_MASK, SE_FIXED);
      end
      IDX_RESERVED_ALL_ONES: begin
        read_byte = RESERVED_VALUE;
      end
      IDX_REVISION_AND_VENDOR: begin
        read_byte = {REVISION_CODE, VENDOR_CODE};
      end
      IDX_FAMILY_AND_PART: begin
        read_byte = {FAMILY_CODE, PART_CODE};
      end
      IDX_BLOCK_READ_LENGTH: begin
        read_byte = shown(st.read_length, LENGTH_MASK,
                          LENGTH_FIXED);
      end
      default: begin
        read_byte = UNMAPPED_VALUE;  // beyond the bank
      end
    endcase
  endfunction : read_byte

  // ----------------------------------------------------------------
  // bus line events
  // ----------------------------------------------------------------
  logic scl_rise;  // clock line rose
  logic scl_fall;  // clock line fell
  logic bus_start;  // data fell with clock high
  logic bus_stop;  // data rose with clock high
  logic [6:0] own_addr;  // address picked by the strap
  logic [7:0] tx_byte;  // byte at the pointer

  assign scl_rise = SCL & ~s.scl_q;
  assign scl_fall = ~SCL & s.scl_q;
  assign bus_start = SCL & s.scl_q & s.sda_q & ~SDA_IN;
  assign bus_stop = SCL & s.scl_q & ~s.sda_q & SDA_IN;
  assign own_addr = s.addr_sel ? BUS_ADDR_1 : BUS_ADDR_0;
  assign tx_byte = read_byte(s, s.index);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one process drives the whole engine; data changes only while
  // the clock line is low, so start and stop stay unambiguous
  always_comb begin
    next_s = s;
    next_s.scl_q = SCL;
    next_s.sda_q = SDA_IN;
    next_s.wr_strobe = 1'b0;
    next_s.first_tx = 1'b0;
    // straps are caught in the first cycle after reset
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1;
      next_s.strap = SPREAD_STRAP_CODE;
      next_s.addr_sel = ADDR_SELECT;
    end
    if (bus_start) begin
      // start or repeated start: expect an address
      next_s.phase = CGB_RX;
      next_s.role = ROLE_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.sda_low = 1'b0;
    end else if (bus_stop) begin
      next_s.phase = CGB_IDLE;
      next_s.sda_low = 1'b0;
    end else begin
      case (s.phase)
        CGB_RX: begin
          // sample on the rising clock
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], SDA_IN};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
          // after the eighth bit decide whether to acknowledge
          if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
            next_s.bit_cnt = 4'h0;
            next_s.phase = CGB_ACK_OUT;
            next_s.sda_low = 1'b1;
            case (s.role)
              ROLE_ADDR: begin
                if (s.shift[7:1] == own_addr) begin
                  next_s.rw = s.shift[0];
                end else begin
                  // not ours: stay off the bus until next start
                  next_s.phase = CGB_IDLE;
                  next_s.sda_low = 1'b0;
                end
              end
              ROLE_INDEX: begin
                next_s.index = s.shift;
              end
              ROLE_COUNT: begin
                // the count only frames the host's burst
                next_s.index = s.index;
              end
              default: begin
                // data byte: store writable bits only
                next_s.wr_strobe = 1'b1;
                next_s.index = s.index + 8'h01;
                case (s.index)
                  IDX_OUTPUT_PAIR_ENABLE: begin
                    next_s.pair_enable = merge(s.pair_enable, s.shift,
                                              PAIR_ENABLE_MASK);
                  end
                  IDX_SPREAD_AND_SWING: begin
                    next_s.spread = merge(s.spread, s.shift,
                                          SPREAD_MASK);
                  end
                  IDX_PAIR_EDGE_RATE: begin
                    next_s.edge_rate = merge(s.edge_rate, s.shift,
                                             EDGE_MASK);
                  end
                  IDX_SINGLE_ENDED_CTRL: begin
                    next_s.se_ctrl = merge(s.se_ctrl, s.shift, SE_MASK);
                  end
                  IDX_BLOCK_READ_LENGTH: begin
                    next_s.read_length = merge(s.read_length, s.shift,
                                               LENGTH_MASK);
                  end
                  default: begin
                    // read-only and reserved bytes keep their value
                    next_s.se_ctrl = s.se_ctrl;
                  end
                endcase
              end
            endcase
          end
        end
        CGB_ACK_OUT: begin
          // release after the acknowledge clock
          if (scl_fall) begin
            next_s.sda_low = 1'b0;
            next_s.bit_cnt = 4'h0;
            next_s.phase = CGB_RX;
            case (s.role)
              ROLE_ADDR: begin
                if (s.rw) begin
                  // read: the count byte goes out first
                  next_s.phase = CGB_TX;
                  next_s.role = ROLE_DATA;
                  next_s.first_tx = 1'b1;
                  next_s.shift = read_byte(s, IDX_BLOCK_READ_LENGTH);
                  next_s.sda_low = ~next_s.shift[7];
                end else begin
                  next_s.role = ROLE_INDEX;
                end
              end
              ROLE_INDEX: begin
                next_s.role = ROLE_COUNT;
              end
              default: begin
                next_s.role = ROLE_DATA;
              end
            endcase
          end
        end
        CGB_TX: begin
          // shift out on each falling clock
          if (scl_fall) begin
            if (s.bit_cnt == LAST_TX_BIT) begin
              next_s.phase = CGB_ACK_IN;
              next_s.sda_low = 1'b0;
            end else begin
              next_s.bit_cnt = s.bit_cnt + 4'h1;
              next_s.sda_low = ~s.shift[6];
              next_s.shift = {s.shift[6:0], 1'b0};
            end
          end
        end
        CGB_ACK_IN: begin
          if (scl_rise) begin
            next_s.host_nack = SDA_IN;
          end
          // a host not-acknowledge ends the read
          if (scl_fall) begin
            if (s.host_nack) begin
              next_s.phase = CGB_IDLE;
            end else begin
              next_s.phase = CGB_TX;
              next_s.bit_cnt = 4'h0;
              next_s.shift = tx_byte;
              next_s.sda_low = ~tx_byte[7];
              next_s.index = s.index + 8'h01;
            end
          end
        end
        default: begin
          next_s.sda_low = 1'b0;  // idle: bus released
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset values are constants; straps are sampled after release
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s <= '0;
      s.phase <= CGB_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.pair_enable <= PAIR_ENABLE_RESET;
      s.spread <= SPREAD_RESET;
      s.edge_rate <= EDGE_RESET;
      s.se_ctrl <= SE_RESET;
      s.read_length <= LENGTH_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~s.sda_low;
  // pairs stop low while powered down
  assign PAIR0_OUTPUT_GATE = s.pair_enable[PAIR0_BIT]
                             & POWER_GOOD_POWERDOWN_PIN_N;
  assign PAIR1_OUTPUT_GATE = s.pair_enable[PAIR1_BIT]
                             & POWER_GOOD_POWERDOWN_PIN_N;
  assign PAIR0_EDGE_RATE = s.edge_rate[PAIR0_BIT];
  assign PAIR1_EDGE_RATE = s.edge_rate[PAIR1_BIT];
  // software field counts only when override is set
  assign SPREAD_AMOUNT = s.spread[SW_OVERRIDE_BIT]
                         ? s.spread[SW_SPREAD_LSB +: 2]
                         : s.strap;
  assign SWING_SELECT = s.spread[SWING_LSB +: 2];
  assign SE_EDGE_RATE = s.se_ctrl[SE_EDGE_LSB +: 2];
  assign SE_OUTPUT_RUN = s.se_ctrl[SE_ENABLE_BIT]
                         & (POWER_GOOD_POWERDOWN_PIN_N
                            | s.se_ctrl[SE_WAKE_BIT]);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_data_commit;
    s.wr_strobe;
  endsequence

  sequence seq_read_open;
    s.first_tx;
  endsequence

  AST_PAIR_GATED: assert property (@(posedge CLOCK) disable iff (SRST)
    !s.pair_enable[PAIR1_BIT] |-> !PAIR1_OUTPUT_GATE)
    else $error("pair1 ran while disabled");

  AST_STRAP_READBACK: assert property (@(posedge CLOCK) disable iff (SRST)
    s.strap_taken |->
      tx_byte[7:6] == s.strap || s.index != IDX_SPREAD_AND_SWING)
    else $error("strap readback wrong");

  AST_SPREAD_LOCKED: assert property (@(posedge CLOCK) disable iff (SRST)
    !s.spread[SW_OVERRIDE_BIT] |-> SPREAD_AMOUNT == s.strap)
    else $error("spread not locked to strap");

  AST_SPREAD_SOFT: assert property (@(posedge CLOCK) disable iff (SRST)
    s.spread[SW_OVERRIDE_BIT] |->
      SPREAD_AMOUNT == s.spread[SW_SPREAD_LSB +: 2])
    else $error("software spread ignored");

  AST_RESET_DEFAULTS: assert property (@(posedge CLOCK)
    !SRST && $past(SRST) |-> SWING_SELECT == 2'h2 && SE_EDGE_RATE == 2'h1
      && PAIR0_EDGE_RATE && !s.se_ctrl[SE_WAKE_BIT]
      && s.read_length == 8'h08)
    else $error("reset defaults wrong");

  AST_SE_POWERDOWN: assert property (@(posedge CLOCK) disable iff (SRST)
    !POWER_GOOD_POWERDOWN_PIN_N && !s.se_ctrl[SE_WAKE_BIT]
      |-> !SE_OUTPUT_RUN)
    else $error("single-ended ran in power down");

  AST_RESERVED_ONES: assert property (@(posedge CLOCK) disable iff (SRST)
    s.index == IDX_RESERVED_ALL_ONES |-> tx_byte == 8'hFF)
    else $error("reserved byte not all ones");

  AST_ID_FIXED: assert property (@(posedge CLOCK) disable iff (SRST)
    seq_data_commit |=> $stable(read_byte(s, IDX_FAMILY_AND_PART))
      && $stable(read_byte(s, IDX_REVISION_AND_VENDOR)))
    else $error("identity bytes changed");

  AST_INDEX_STEP: assert property (@(posedge CLOCK) disable iff (SRST)
    seq_data_commit |-> s.index == $past(s.index) + 8'h01)
    else $error("index did not advance");

  AST_WRITE_ACKED: assert property (@(posedge CLOCK) disable iff (SRST)
    seq_data_commit |-> !SDA_OE_N && s.phase == CGB_ACK_OUT)
    else $error("data byte not acknowledged");

  AST_COUNT_FIRST: assert property (@(posedge CLOCK) disable iff (SRST)
    seq_read_open |-> s.shift == {3'h0, s.read_length[4:0]})
    else $error("read did not open with count");

endmodule : cgb_config_bank

// ==== cgb_host_model.sv ====
`timescale 1ns/100ps
module cgb_host_model (
  // clock and wired data level
  input wire logic clock,
  input wire logic sda,
  // bus drive, pull is active high
  output logic scl,
  output logic sda_pull,
  // last nine-bit frame seen on the wire
  output logic [8:0] res,
  output logic res_valid
);
  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res = 9'h000;
    res_valid = 1'b0;
  end
  // every move lands on a falling edge; phases last two or four cycles
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask : wt
  // one bit: data moves only while the bus clock is low
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_pull = ~b;
    wt(2);
    scl = 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl = 1'b0;
  endtask : bit_io
  // start or repeated start: data falls while clock is high
  task automatic start_cond();
    wt(2);
    sda_pull = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask : start_cond
  // stop leaves clock high and data released between frames
  task automatic stop_cond();
    wt(2);
    sda_pull = 1'b1;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_pull = 1'b0;
    wt(4);
  endtask : stop_cond
  // eight bits msb first plus the acknowledge slot, read back off the wire
  task automatic frame(input logic [8:0] tx);
    logic [8:0] rx;
    for (int i = 8; i >= 0; i--) bit_io(tx[i], rx[i]);
    res = rx;
    res_valid = 1'b1;
    wt(1);
    res_valid = 1'b0;
  endtask : frame
endmodule : cgb_host_model

// ==== tb_clock_gen_smbus_config_bank.sv ====
`timescale 1ns/100ps
module tb_clock_gen_smbus_config_bank;
  import cgb_pkg::*;
  // ----
  // settings handed to the bank
  // ----
  localparam logic [6:0] A0 = 7'h2A;  // arbitrary address
  localparam logic [6:0] A1 = 7'h2B;  // arbitrary address
  localparam logic [3:0] REV = 4'hA;  // arbitrary value
  localparam logic [3:0] VEN = 4'hC;  // arbitrary value
  localparam logic [1:0] FAM = 2'h1;  // arbitrary value
  localparam logic [5:0] PART = 6'h2D;  // arbitrary value
  // ----
  // nets, expected image, notes
  // ----
  logic clk = 1'b0;  // 25 MHz
  logic srst = 1'b1;  // held from time zero
  logic addr_sel = 1'b0;
  logic [1:0] strap = 2'h0;
  logic pg_n = 1'b1;  // powered
  logic pin_stb = 1'b0;  // asks the monitor to sample the controls
  logic scl, pull, oe_n, sda_out, res_valid, p0g, p1g, p0e, p1e, ser;
  logic [1:0] spr, swg, see;
  logic [8:0] res;
  logic [7:0] rm [0:7];  // register image kept from the rules
  logic [7:0] wd [0:7];  // bytes for the next block write
  logic [11:0] notes [$];  // kind bit, then expected value
  logic [11:0] e;
  logic [31:0] seed = 32'h0000_001E;  // xorshift state
  int miscompares = 0;
  int check_count = 0;
  wire sda = ~pull & (oe_n | sda_out);  // wired line with pull-up
  wire [10:0] pins = {p0g, p1g, p0e, p1e, spr, swg, see, ser};
  cgb_config_bank #(.BUS_ADDR_0(A0), .BUS_ADDR_1(A1), .REVISION_CODE(REV),
    .VENDOR_CODE(VEN), .FAMILY_CODE(FAM), .PART_CODE(PART))
  u_cgb_config_bank (.CLOCK(clk), .SRST(srst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(oe_n), .ADDR_SELECT(addr_sel),
    .SPREAD_STRAP_CODE(strap), .POWER_GOOD_POWERDOWN_PIN_N(pg_n),
    .PAIR0_OUTPUT_GATE(p0g), .PAIR1_OUTPUT_GATE(p1g),
    .PAIR0_EDGE_RATE(p0e), .PAIR1_EDGE_RATE(p1e), .SPREAD_AMOUNT(spr),
    .SWING_SELECT(swg), .SE_EDGE_RATE(see), .SE_OUTPUT_RUN(ser));
  cgb_host_model host (.clock(clk), .sda(sda), .scl(scl), .sda_pull(pull),
    .res(res), .res_valid(res_valid));
  // free-running clock
  always #20 clk = ~clk;
  // ----
  // helpers
  // ----
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // indices past the bank read zero
  function automatic logic [7:0] rv(input int i);
    return (i < 8) ? rm[i] : 8'h00;
  endfunction : rv
  // controls follow register bits, power pin and latched strap
  function automatic logic [10:0] pexp();
    return {rm[0][1] & pg_n, rm[0][2] & pg_n, rm[2][1], rm[2][2],
      rm[1][5] ? rm[1][4:3] : rm[1][7:6], rm[1][1:0], rm[3][7:6],
      rm[3][4] & (pg_n | rm[3][5])};
  endfunction : pexp
  // writable masks; read-only and reserved places keep their value
  task automatic mwr(input int i, input logic [7:0] v);
    case (i)
      0, 2: rm[i] = (v & 8'h06) | 8'hF9;
      1: rm[i] = (v & 8'h3B) | (rm[1] & 8'hC4);
      3: rm[i] = (v & 8'hF0) | 8'h0F;
      7: rm[i] = v & 8'h1F;
      default: ;
    endcase
  endtask : mwr
  // reset with straps; image returns to its documented defaults
  task automatic do_reset(input logic [1:0] s, input logic a);
    @(negedge clk);
    srst = 1'b1;
    strap = s;
    addr_sel = a;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    rm = '{8'hFF, {s, 6'h06}, 8'hFF, 8'h5F, 8'hFF, {REV, VEN},
      {FAM, PART}, 8'h08};
  endtask : do_reset
  // one frame: note what the wire must show, then send it
  task automatic fr(input logic [7:0] tx, input logic hb,
      input logic [8:0] ex);
    notes.push_back({3'h0, ex});
    host.frame({tx, hb});
  endtask : fr
  // sampled by the monitor one edge later
  task automatic chk_pins();
    notes.push_back({1'b1, pexp()});
    @(negedge clk);
    pin_stb = 1'b1;
    @(negedge clk);
    pin_stb = 1'b0;
  endtask : chk_pins
  task automatic blk_wr(input logic [6:0] a, input logic [7:0] idx,
      input int n, input logic ok);
    host.start_cond();
    fr({a, 1'b0}, 1'b1, {a, 1'b0, ~ok});
    if (ok) begin
      fr(idx, 1'b1, {idx, 1'b0});
      fr(n[7:0], 1'b1, {n[7:0], 1'b0});
      for (int i = 0; i < n; i++) begin
        fr(wd[i], 1'b1, {wd[i], 1'b0});
        mwr(idx + i, wd[i]);
      end
    end
    host.stop_cond();
  endtask : blk_wr
  // host acks every byte but the last, which it refuses
  task automatic blk_rd(input logic [6:0] a, input logic [7:0] idx,
      input int n);
    host.start_cond();
    fr({a, 1'b0}, 1'b1, {a, 2'b00});
    fr(idx, 1'b1, {idx, 1'b0});
    host.start_cond();
    fr({a, 1'b1}, 1'b1, {a, 2'b10});
    fr(8'hFF, 1'b0, {3'h0, rm[7][4:0], 1'b0});
    for (int i = 0; i < n; i++)
      fr(8'hFF, i == n - 1, {rv(idx + i), i == n - 1});
    host.stop_cond();
  endtask : blk_rd
  // ----
  // monitor: oldest note against each result as it appears
  // ----
  task automatic cmp_bus(input logic [8:0] ex);
    check_count++;
    if (res !== ex) begin
      miscompares++;
      $display("[ERR] %0t frame %h expected %h", $time, res, ex);
    end
  endtask : cmp_bus
  task automatic cmp_pins(input logic [10:0] ex);
    check_count++;
    if (pins !== ex) begin
      miscompares++;
      $display("[ERR] %0t controls %h expected %h", $time, pins, ex);
    end
  endtask : cmp_pins
  always @(posedge clk) begin
    if (res_valid || pin_stb) begin
      e = notes.pop_front();
      if (e[11]) cmp_pins(e[10:0]);
      else cmp_bus(e[8:0]);
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // ----
  // tests
  // ----
  initial begin
    do_reset(STRAP_MID, 1'b0);
    chk_pins();
    blk_rd(A0, 8'h00, 9);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) wd[i] = rnd();
    blk_wr(A0, 8'h00, 8, 1'b1);
    blk_rd(A0, 8'h00, 8);
    chk_pins();
    $display("test random block done");
    // every override and software code, with the power pin moving
    for (int k = 0; k < 16; k++) begin
      wd[0] = rnd();
      wd[1] = {2'b00, k[2:0], 1'b0, k[3], k[0]};
      wd[2] = rnd();
      wd[3] = rnd();
      blk_wr(A0, 8'h00, 4, 1'b1);
      pg_n = k[1] ^ k[3];
      chk_pins();
    end
    pg_n = 1'b1;
    $display("test controls done");
    for (int i = 0; i < 4; i++) wd[i] = rnd();
    blk_wr(A0, 8'h04, 4, 1'b1);
    blk_rd(A0, 8'h04, 6);
    blk_wr(A1, 8'h00, 0, 1'b0);
    blk_rd(A0, 8'h00, 2);
    $display("test fixed places done");
    // each strap level, second address selected
    for (int i = 0; i < 3; i++) begin
      do_reset(i == 0 ? STRAP_LOW : i == 1 ? STRAP_MID : STRAP_HIGH, 1'b1);
      chk_pins();
      blk_rd(A1, 8'h01, 1);
      blk_wr(A0, 8'h00, 0, 1'b0);
    end
    $display("test straps done");
    conclude();
  end
  // watchdog: about two and a half times the expected run of some 14800 cycles
  initial begin
    #1500000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : tb_clock_gen_smbus_config_bank
